// File: common/switch_node_config_params.svh
// constants of the switch node configuration register bank
// assumes a 32-bit configuration access port with word-numbered registers
`ifndef SWITCH_NODE_CONFIG_PARAMS_SVH
`define SWITCH_NODE_CONFIG_PARAMS_SVH
`define NUM_PLL_SETTINGS    8'h06
`define NUM_SWITCH_CLK_DIV  8'h07
`define NUM_REF_CLK_DIV     8'h08
`define NUM_TEST_PORT_ID    8'h09
`define NUM_USER_CODE       8'h0A
`define NUM_ROUTE_LOW       8'h0C
`define NUM_ROUTE_HIGH      8'h0D
`define NUM_DEBUG_TILE0     8'h10
`define NUM_DEBUG_TILE1     8'h11
`define NUM_DEBUG_ORIGIN    8'h1F
`define NUM_LINK_BASE       8'h20
`define PLL_NO_RESET_BIT    31
`define PLL_NO_WAIT_BIT     30
`define PLL_BYPASS_BIT      29
`define PLL_TAP_BOOT_BIT    28
`define PLL_SETTINGS_MASK   32'hF39F_FF7F
`define SWCFG_PLL_LOCK_BIT  8
`define REF_DIV_RESET       16'h0003
`define SW_DIV_RESET        16'h0000
`define PLL_RESET_VALUE     32'h0000_0000
`define DBG_REQ_EN_BIT      1
`define DBG_DRIVE_EN_BIT    0
`define ORIGIN_PIN_BIT      4
`define ORIGIN_MASK         32'h0000_0013
`define LINK_WR_MASK        32'h0000_0F30
`define TILE_RESET_CYCLES   4
`endif

// File: common/switch_node_config_pkg.sv
// types of the switch node configuration register bank
// assumes the params header supplies all numeric constants
package switch_node_config_pkg;
    typedef logic [3:0] route_dir_t;
    typedef logic [1:0] target_type_t;
    typedef enum logic [1:0] {
        PLL_IDLE   = 2'b00,
        PLL_RESET  = 2'b01,
        PLL_RELOCK = 2'b10
    } pll_phase_e;
endpackage

// File: core/switch_node_config_regs.sv
// configuration register bank of a packet-switch node
// assumes config accesses arrive synchronous to core_clk as one-cycle strobes;
// link status, lock and debug inputs from the same clock domain, except the
// external debug pin, which is synchronised here
`include "switch_node_config_params.svh"
`timescale 1ns/10ps
`default_nettype none
module switch_node_config_regs
    import switch_node_config_pkg::*;
#(
    parameter int NUM_LINKS          = 9,
    parameter logic [31:0] TEST_PORT_ID_VAL = 32'h1234_5001,  // arbitrary value
    parameter logic [17:0] FIX_ID_VAL       = 18'h0_0001      // arbitrary value
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic                    cfg_wr,
    input  wire logic                    cfg_rd,
    input  wire logic [7:0]              cfg_num,
    input  wire logic [31:0]             cfg_wdata,
    output logic [31:0]                  cfg_rdata,
    output logic                         cfg_rvalid,
    input  wire logic                    pll_write_lock,
    input  wire logic                    pll_locked,
    output logic [31:0]                  pll_settings,
    output logic                         pll_bypass,
    output logic                         tap_boot_select,
    output logic                         tile_reset,
    output logic [15:0]                  switch_clk_div,
    output logic [15:0]                  ref_clk_div,
    input  wire logic [13:0]             otp_user_code,
    input  wire logic [15:0]             own_node_id,
    input  wire logic [15:0]             dest_node_id,
    output logic [3:0]                   route_dir,
    output logic                         route_local,
    input  wire logic                    debug_pin_n,
    input  wire logic [1:0]              core_halted_flag,
    output logic [1:0]                   debug_request,
    output logic                         shared_debug_line,
    input  wire logic [NUM_LINKS*2-1:0]  link_target_type,
    input  wire logic [NUM_LINKS*8-1:0]  link_dest_num,
    input  wire logic [NUM_LINKS-1:0]    link_junk,
    input  wire logic [NUM_LINKS-1:0]    link_dest_busy,
    input  wire logic [NUM_LINKS-1:0]    link_src_busy,
    output logic [NUM_LINKS*4-1:0]       link_dir,
    output logic [NUM_LINKS*2-1:0]       link_net
);

    initial begin
        if (NUM_LINKS < 1 || NUM_LINKS > 32) begin
            $error("NUM_LINKS must lie in 1..32");
        end
    end

    typedef struct packed {
        logic [31:0]           pll;
        pll_phase_e            phase;
        logic [2:0]            rst_cnt;
        logic [15:0]           sw_div;
        logic [15:0]           ref_div;
        logic [31:0]           route_lo;
        logic [31:0]           route_hi;
        logic [1:0]            dbg_t0;
        logic [1:0]            dbg_t1;
        logic [2:0]            origin;
        logic                  line_prev;
        logic [1:0]            pin_sync;
        logic [NUM_LINKS*4-1:0] ldir;
        logic [NUM_LINKS*2-1:0] lnet;
        logic [31:0]           rdata;
        logic                  rvalid;
        logic [3:0]            rdir;
        logic                  rlocal;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    // direction nibble for a dimension across both routing words
    function automatic logic [3:0] dir_of(input logic [63:0] tbl, input logic [3:0] dim);
        dir_of = tbl[{dim, 2'b00} +: 4];
    endfunction

    // position of the most significant set bit of a mismatch vector
    function automatic logic [3:0] top_bit(input logic [15:0] v);
        top_bit = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) begin
                top_bit = 4'(i);
            end
        end
    endfunction

    // link status word assembled from live state and stored fields
    function automatic logic [31:0] link_word(input int k, input state_s s);
        link_word = 32'h0;
        link_word[25:24] = link_target_type[k*2 +: 2];
        link_word[23:16] = link_dest_num[k*8 +: 8];
        link_word[11:8]  = s.ldir[k*4 +: 4];
        link_word[5:4]   = s.lnet[k*2 +: 2];
        link_word[2]     = link_junk[k];
        link_word[1]     = link_dest_busy[k];
        link_word[0]     = link_src_busy[k];
    endfunction

    logic        line_now;
    logic        pin_active;
    logic [15:0] mismatch;

    // shared debug line is an or of enabled halted cores and the pin
    always_comb begin
        pin_active = ~st_r.pin_sync[1];
        line_now   = pin_active
                   | (st_r.dbg_t0[`DBG_DRIVE_EN_BIT] & core_halted_flag[0])
                   | (st_r.dbg_t1[`DBG_DRIVE_EN_BIT] & core_halted_flag[1]);
        mismatch   = own_node_id ^ dest_node_id;
    end

    // next-state logic for every register of the bank
    always_comb begin
        st_nxt          = st_r;
        st_nxt.rvalid   = cfg_rd;
        st_nxt.pin_sync = {st_r.pin_sync[0], debug_pin_n};
        st_nxt.line_prev = line_now;
        // routing lookup is registered so the route output comes from a flop
        st_nxt.rlocal   = (mismatch == 16'h0000);
        st_nxt.rdir     = dir_of({st_r.route_hi, st_r.route_lo}, top_bit(mismatch));

        // tile reset sequencing after a settings write
        case (st_r.phase)
            PLL_IDLE: begin
            end
            PLL_RESET: begin
                if (st_r.rst_cnt == 3'd0) begin
                    st_nxt.phase = PLL_IDLE;
                end else begin
                    st_nxt.rst_cnt = st_r.rst_cnt - 3'd1;
                end
            end
            PLL_RELOCK: begin
                // keep the tile held until the pll reports lock again
                if (pll_locked) begin
                    st_nxt.phase   = PLL_RESET;
                    st_nxt.rst_cnt = 3'(`TILE_RESET_CYCLES - 1);
                end
            end
            default: begin
                st_nxt.phase = PLL_IDLE;
            end
        endcase

        if (cfg_wr) begin
            case (cfg_num)
                `NUM_PLL_SETTINGS: begin
                    if (!pll_write_lock) begin
                        st_nxt.pll = cfg_wdata & `PLL_SETTINGS_MASK;
                        if (!cfg_wdata[`PLL_NO_RESET_BIT]) begin
                            if (cfg_wdata[`PLL_NO_WAIT_BIT]) begin
                                st_nxt.phase   = PLL_RESET;
                                st_nxt.rst_cnt = 3'(`TILE_RESET_CYCLES - 1);
                            end else begin
                                st_nxt.phase = PLL_RELOCK;
                            end
                        end
                    end
                end
                `NUM_SWITCH_CLK_DIV: st_nxt.sw_div   = cfg_wdata[15:0];
                `NUM_REF_CLK_DIV:    st_nxt.ref_div  = cfg_wdata[15:0];
                `NUM_ROUTE_LOW:      st_nxt.route_lo = cfg_wdata;
                `NUM_ROUTE_HIGH:     st_nxt.route_hi = cfg_wdata;
                `NUM_DEBUG_TILE0:    st_nxt.dbg_t0   = cfg_wdata[1:0];
                `NUM_DEBUG_TILE1:    st_nxt.dbg_t1   = cfg_wdata[1:0];
                `NUM_DEBUG_ORIGIN: begin
                    st_nxt.origin = {cfg_wdata[`ORIGIN_PIN_BIT], cfg_wdata[1:0]};
                end
                default: begin
                    for (int k = 0; k < NUM_LINKS; k++) begin
                        if (cfg_num == 8'(`NUM_LINK_BASE + k)) begin
                            st_nxt.ldir[k*4 +: 4] = cfg_wdata[11:8];
                            st_nxt.lnet[k*2 +: 2] = cfg_wdata[5:4];
                        end
                    end
                end
            endcase
        end

        // a rising shared debug event latches who raised it; it wins over a software write
        if (line_now && !st_r.line_prev) begin
            st_nxt.origin = {pin_active,
                             st_r.dbg_t1[`DBG_DRIVE_EN_BIT] & core_halted_flag[1],
                             st_r.dbg_t0[`DBG_DRIVE_EN_BIT] & core_halted_flag[0]};
        end

        // read mux; unknown numbers and reserved bits return zero
        st_nxt.rdata = 32'h0;
        if (cfg_rd) begin
            case (cfg_num)
                `NUM_PLL_SETTINGS:   st_nxt.rdata = st_r.pll;
                `NUM_SWITCH_CLK_DIV: st_nxt.rdata = {16'h0, st_r.sw_div};
                `NUM_REF_CLK_DIV:    st_nxt.rdata = {16'h0, st_r.ref_div};
                `NUM_TEST_PORT_ID:   st_nxt.rdata = TEST_PORT_ID_VAL;
                `NUM_USER_CODE:      st_nxt.rdata = {otp_user_code, FIX_ID_VAL};
                `NUM_ROUTE_LOW:      st_nxt.rdata = st_r.route_lo;
                `NUM_ROUTE_HIGH:     st_nxt.rdata = st_r.route_hi;
                `NUM_DEBUG_TILE0:    st_nxt.rdata = {30'h0, st_r.dbg_t0};
                `NUM_DEBUG_TILE1:    st_nxt.rdata = {30'h0, st_r.dbg_t1};
                `NUM_DEBUG_ORIGIN:   st_nxt.rdata = {27'h0, st_r.origin[2], 2'b00, st_r.origin[1:0]};
                default: begin
                    for (int k = 0; k < NUM_LINKS; k++) begin
                        if (cfg_num == 8'(`NUM_LINK_BASE + k)) begin
                            st_nxt.rdata = link_word(k, st_r);
                        end
                    end
                end
            endcase
        end
    end

    // single state register; synchronous reset to documented values
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r          <= '0;
            st_r.pll      <= `PLL_RESET_VALUE;
            st_r.phase    <= PLL_IDLE;
            st_r.sw_div   <= `SW_DIV_RESET;
            st_r.ref_div  <= `REF_DIV_RESET;
            st_r.pin_sync <= 2'b11;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs; debug request is combinational so a halt spreads at once
    always_comb begin
        cfg_rdata        = st_r.rdata;
        cfg_rvalid       = st_r.rvalid;
        pll_settings     = st_r.pll;
        pll_bypass       = st_r.pll[`PLL_BYPASS_BIT];
        tap_boot_select  = st_r.pll[`PLL_TAP_BOOT_BIT];
        tile_reset       = (st_r.phase != PLL_IDLE);
        switch_clk_div   = st_r.sw_div;
        ref_clk_div      = st_r.ref_div;
        route_dir        = st_r.rdir;
        route_local      = st_r.rlocal;
        shared_debug_line = line_now;
        debug_request[0] = line_now & st_r.dbg_t0[`DBG_REQ_EN_BIT];
        debug_request[1] = line_now & st_r.dbg_t1[`DBG_REQ_EN_BIT];
        link_dir         = st_r.ldir;
        link_net         = st_r.lnet;
    end

endmodule
`default_nettype wire

// File: tb/pll_lock_model.sv
// far-side model: a pll that loses lock while the tile is held in reset
// assumes tile_reset comes from the register bank on the same clock
`timescale 1ns/10ps
`default_nettype none
module pll_lock_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       tile_reset,
    input  wire logic [7:0] lock_delay,
    output logic            pll_locked
);
    logic       lk_r;
    logic       tr_r;
    logic [7:0] cnt_r;
    // lock drops in the first reset cycle, so a stale lock is seen only if a settings write lands while tile_reset is already high
    assign pll_locked = lk_r && !(tile_reset && !tr_r);
    // relock lock_delay+1 cycles after lock drops, slow or prompt as the bench sets
    always @(posedge core_clk) begin
        tr_r <= tile_reset;
        if (rst) begin
            lk_r <= 1'b1;
            cnt_r <= 8'h00;
        end else if (tile_reset && !tr_r) begin
            lk_r <= 1'b0;
            cnt_r <= lock_delay;
        end else if (!lk_r) begin
            if (cnt_r == 8'h00) lk_r <= 1'b1;
            else cnt_r <= cnt_r - 8'h01;
        end
    end
endmodule
`default_nettype wire

// File: tb/switch_node_config_properties.sv
// checker of the switch node configuration register bank, bound to its ports
// assumes one clock domain, reset synchronous and active high
`timescale 1ns/10ps
`default_nettype none
module switch_node_config_properties (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        cfg_wr,
    input  wire logic [7:0]  cfg_num,
    input  wire logic [31:0] cfg_wdata,
    input  wire logic        pll_write_lock,
    input  wire logic [31:0] pll_settings,
    input  wire logic        pll_bypass,
    input  wire logic        tap_boot_select,
    input  wire logic        tile_reset,
    input  wire logic [15:0] ref_clk_div,
    input  wire logic [15:0] own_node_id,
    input  wire logic [15:0] dest_node_id,
    input  wire logic        route_local,
    input  wire logic [1:0]  debug_request,
    input  wire logic        shared_debug_line
);
    logic w06;
    // a settings write that the lock does not block
    assign w06 = cfg_wr && cfg_num == 8'h06 && !pll_write_lock;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_TILE_RESET: assert property (w06 && !cfg_wdata[31] |=> tile_reset)
        else $error("tile reset missing after settings write");
    AST_SKIP_RESET: assert property (w06 && cfg_wdata[31] && !tile_reset |=> !tile_reset)
        else $error("tile reset despite suppress bit");
    AST_NO_RELOCK_WAIT: assert property (w06 && cfg_wdata[31:30] == 2'b01 && !tile_reset
        |=> tile_reset [*4] ##1 !tile_reset) else $error("no-wait reset not four cycles");
    AST_BYPASS: assert property (pll_bypass == pll_settings[29])
        else $error("bypass differs from stored bit");
    AST_TAP_BOOT: assert property (tap_boot_select == pll_settings[28])
        else $error("boot select differs from stored bit");
    AST_PLL_FIELDS: assert property (w06 |=> pll_settings == ($past(cfg_wdata) & 32'hF39F_FF7F))
        else $error("settings fields not stored");
    AST_WRITE_LOCK: assert property (cfg_wr && cfg_num == 8'h06 && pll_write_lock
        |=> $stable(pll_settings) && !$rose(tile_reset)) else $error("locked settings changed");
    AST_ROUTE_LOCAL: assert property (!$past(rst) |-> route_local ==
        ($past(own_node_id) == $past(dest_node_id))) else $error("local route flag wrong");
    AST_REF_RESET: assert property ($fell(rst) |-> ref_clk_div == 16'h0003)
        else $error("reference divider reset value wrong");
    AST_DEBUG_REQ: assert property (!shared_debug_line |-> debug_request == 2'b00)
        else $error("debug request without shared debug");
endmodule
bind switch_node_config_regs switch_node_config_properties chk (.core_clk, .rst, .cfg_wr, .cfg_num,
    .cfg_wdata, .pll_write_lock, .pll_settings, .pll_bypass, .tap_boot_select, .tile_reset,
    .ref_clk_div, .own_node_id, .dest_node_id, .route_local, .debug_request, .shared_debug_line);
`default_nettype wire

// File: tb/switch_node_config_regs_test.sv
// self-checking bench of the switch node configuration register bank
// assumes the lock model drives pll_locked and the checker is bound
`timescale 1ns/10ps
`default_nettype none
module switch_node_config_regs_test;
    typedef struct {logic [7:0] n; logic [31:0] d; logic [31:0] e;} row_s;
    logic        core_clk, rst, cfg_wr, cfg_rd, cfg_rvalid, pll_write_lock, pll_locked;
    logic        pll_bypass, tap_boot_select, tile_reset, route_local, debug_pin_n, shared_debug_line;
    logic [7:0]  cfg_num, lock_delay;
    logic [31:0] cfg_wdata, cfg_rdata, pll_settings, got;
    logic [15:0] switch_clk_div, ref_clk_div, own_node_id, dest_node_id;
    logic [13:0] otp_user_code;
    logic [3:0]  route_dir;
    logic [1:0]  core_halted_flag, debug_request;
    logic [17:0] link_target_type, link_net;
    logic [71:0] link_dest_num;
    logic [8:0]  link_junk, link_dest_busy, link_src_busy;
    logic [35:0] link_dir;
    int          fails, cmp_count, c;
    // write data beside the value expected back; reserved bits must read zero
    logic [63:0] route_tbl;
    row_s rows[13] = '{'{8'h06, 32'hFFFF_FFFF, 32'hF39F_FF7F}, '{8'h07, 32'hFFFF_FFFF, 32'h0000_FFFF},
        '{8'h08, 32'h1234_ABCD, 32'h0000_ABCD}, '{8'h09, 32'hFFFF_FFFF, 32'h0000_5A5B},
        '{8'h0A, 32'hFFFF_FFFF, {14'h2AAB, 18'h00ABC}}, '{8'h0C, 32'h8765_4321, 32'h8765_4321},
        '{8'h0D, 32'hFEDC_BA98, 32'hFEDC_BA98}, '{8'h10, 32'hFFFF_FFFF, 32'h0000_0003},
        '{8'h11, 32'hFFFF_FFFF, 32'h0000_0003}, '{8'h1F, 32'hFFFF_FFFF, 32'h0000_0013},
        '{8'h20, 32'hFFFF_FFFF, 32'h0000_0F30}, '{8'h28, 32'h0000_0A50, 32'h0000_0A10},
        '{8'h30, 32'hFFFF_FFFF, 32'h0000_0000}};
    switch_node_config_regs #(.TEST_PORT_ID_VAL(32'h0000_5A5B), .FIX_ID_VAL(18'h00ABC)) dut ( // arbitrary ids
        .core_clk, .rst, .cfg_wr, .cfg_rd, .cfg_num, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .pll_write_lock,
        .pll_locked, .pll_settings, .pll_bypass, .tap_boot_select, .tile_reset, .switch_clk_div,
        .ref_clk_div, .otp_user_code, .own_node_id, .dest_node_id, .route_dir, .route_local, .debug_pin_n,
        .core_halted_flag, .debug_request, .shared_debug_line, .link_target_type, .link_dest_num,
        .link_junk, .link_dest_busy, .link_src_busy, .link_dir, .link_net);
    pll_lock_model far (.core_clk, .rst, .tile_reset, .lock_delay, .pll_locked);
    always #5 core_clk = ~core_clk;
    task chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task wr(logic [7:0] n, logic [31:0] d);
        @(posedge core_clk);
        cfg_wr <= 1'b1; cfg_num <= n; cfg_wdata <= d;
        @(posedge core_clk);
        cfg_wr <= 1'b0;
    endtask
    // answer stands one cycle after the read edge, so sample just past it
    task rd(logic [7:0] n);
        @(posedge core_clk);
        cfg_rd <= 1'b1; cfg_num <= n;
        @(posedge core_clk);
        cfg_rd <= 1'b0;
        #1 got = cfg_rvalid ? cfg_rdata : 32'hXXXX_XXXX;
    endtask
    // counts tile reset cycles; bounded so a stuck reset cannot hang the run
    task count_rst(output int k);
        int i;
        k = 0;
        #1;
        for (i = 0; i < 300 && tile_reset === 1'b1; i++) begin
            k++;
            @(posedge core_clk); #1;
        end
        if (i == 300) begin fails++; stop_test; end
    endtask
    initial begin
        core_clk = 0; rst = 1; cfg_wr = 0; cfg_rd = 0; cfg_num = 0; cfg_wdata = 0; pll_write_lock = 0;
        lock_delay = 8'h14; otp_user_code = 14'h2AAB; own_node_id = 0; dest_node_id = 0; debug_pin_n = 1;
        core_halted_flag = 0; link_target_type = 0; link_dest_num = 0; link_junk = 0;
        link_dest_busy = 0; link_src_busy = 0; fails = 0; cmp_count = 0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        rd(8'h08); chk("ref div reset", 32'h3, got);
        rd(8'h07); chk("switch div reset", 32'h0, got);
        rd(8'h0C); chk("route reset", 32'h0, got);
        foreach (rows[i]) begin
            wr(rows[i].n, rows[i].d);
            rd(rows[i].n); chk($sformatf("reg %h", rows[i].n), rows[i].e, got);
        end
        chk("link dir", 32'hF, link_dir[3:0]);
        chk("link net", 32'h3, link_net[1:0]);
        chk("pll bypass", 32'h1, pll_bypass);
        chk("tap boot", 32'h1, tap_boot_select);
        chk("switch div out", 32'hFFFF, switch_clk_div);
        chk("ref div out", 32'hABCD, ref_clk_div);
        wr(8'h06, 32'h0000_0101); count_rst(c); chk("waited relock", 32'h1, c >= 20);
        wr(8'h06, 32'h4000_0101); count_rst(c); chk("no wait reset", 32'd4, c);
        pll_write_lock <= 1'b1;
        wr(8'h06, 32'h0000_0000); count_rst(c); chk("locked reset", 32'd0, c);
        rd(8'h06); chk("locked settings", 32'h4000_0101, got);
        pll_write_lock <= 1'b0;
        route_tbl = {32'hFEDC_BA98, 32'h8765_4321};
        // dimension d: dest differs from own id in bit d and all below
        for (int d = 0; d < 16; d++) begin
            @(posedge core_clk) dest_node_id <= 16'hFFFF >> (15 - d);
            repeat (2) @(posedge core_clk); #1;
            chk("route dir", {28'h0, route_tbl[4*d+:4]}, route_dir);
            chk("route local", 32'h0, route_local);
        end
        @(posedge core_clk) dest_node_id <= 16'h0000;
        repeat (2) @(posedge core_clk); #1;
        chk("route local", 32'h1, route_local);
        @(posedge core_clk) core_halted_flag <= 2'b01;
        repeat (3) @(posedge core_clk); #1;
        chk("shared debug", 32'h1, shared_debug_line);
        chk("debug request", 32'h3, debug_request);
        rd(8'h1F); chk("origin core", 32'h01, got);
        @(posedge core_clk) core_halted_flag <= 2'b00;
        @(posedge core_clk) debug_pin_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        rd(8'h1F); chk("origin pin", 32'h10, got);
        debug_pin_n <= 1'b1;
        wr(8'h10, 32'h0);
        repeat (4) @(posedge core_clk);
        core_halted_flag <= 2'b10;
        repeat (3) @(posedge core_clk); #1;
        chk("request tile one", 32'h2, debug_request);
        rd(8'h1F); chk("origin core one", 32'h02, got);
        link_target_type[7:6] <= 2'b10; link_dest_num[31:24] <= 8'h5A; link_junk[3] <= 1'b1;
        link_dest_busy[3] <= 1'b1; link_src_busy[3] <= 1'b1;
        rd(8'h23); chk("link status", 32'h025A_0007, got);
        stop_test;
    end
endmodule
`default_nettype wire
